// ### hdl/media_regs_pkg.sv
// Package: offsets, field positions, reset values and carrier types for the media control registers
package media_regs_pkg;

	// ----------------------------------------------------------------
	// Bus widths
	// ----------------------------------------------------------------
	localparam int AXI_ADDR_W = 16;
	localparam int AXI_DATA_W = 32;
	localparam int REG_W = 16;
	localparam int STRB_W = AXI_DATA_W / 8;

	// ----------------------------------------------------------------
	// Printed register offsets (group nibble included) and byte addresses
	// ----------------------------------------------------------------
	localparam logic [15:0] OFF_EXT_ABILITY_TWO = 16'h100b;
	localparam logic [15:0] OFF_EXT_ABILITY = 16'h1012;
	localparam logic [15:0] OFF_MEDIUM_ROLE_CONTROL = 16'h1834;
	localparam logic [15:0] OFF_ATTACH_LAYER_CONTROL = 16'h18f6;
	// Group nibble dropped, index times four gives the byte address
	localparam logic [AXI_ADDR_W-1:0] ADDR_EXT_ABILITY_TWO = {2'h0, OFF_EXT_ABILITY_TWO[11:0], 2'h0};
	localparam logic [AXI_ADDR_W-1:0] ADDR_EXT_ABILITY = {2'h0, OFF_EXT_ABILITY[11:0], 2'h0};
	localparam logic [AXI_ADDR_W-1:0] ADDR_MEDIUM_ROLE_CONTROL =
		{2'h0, OFF_MEDIUM_ROLE_CONTROL[11:0], 2'h0};
	localparam logic [AXI_ADDR_W-1:0] ADDR_ATTACH_LAYER_CONTROL =
		{2'h0, OFF_ATTACH_LAYER_CONTROL[11:0], 2'h0};

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int BIT_SINGLE_PAIR_EXT = 11;
	localparam int BIT_LONG_REACH_10M = 2;
	localparam int BIT_ROLE_MASTER = 14;
	localparam int TYPE_LSB = 0;
	localparam int TYPE_MSB = 3;
	localparam logic [3:0] TYPE_10BASE_T1L = 4'h2;
	localparam int BIT_LAYER_RESET = 15;
	localparam int BIT_TX_DISABLE = 14;
	localparam int BIT_AMP_HIGH = 12;
	localparam int BIT_LOW_POWER = 11;
	localparam int BIT_EEE_ENABLE = 10;
	localparam int BIT_LOOPBACK = 0;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [REG_W-1:0] RST_EXT_ABILITY_TWO = 16'h0800;
	localparam logic [REG_W-1:0] RST_EXT_ABILITY = 16'h0004;
	localparam logic [REG_W-1:0] RST_MEDIUM_ROLE_CONTROL = 16'h4002;
	localparam logic [REG_W-1:0] RST_ATTACH_LAYER_CONTROL = 16'h0000;

	// ----------------------------------------------------------------
	// Bus answers and timing
	// ----------------------------------------------------------------
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int LAYER_RESET_CYCLES = 16;
	localparam int RESET_CNT_W = 8;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [0:0] {SEQ_IDLE, SEQ_HOLD} seq_state_t;

	typedef struct packed {
		logic awvalid;
		logic [AXI_ADDR_W-1:0] awaddr;
		logic wvalid;
		logic [AXI_DATA_W-1:0] wdata;
		logic [STRB_W-1:0] wstrb;
		logic bready;
		logic arvalid;
		logic [AXI_ADDR_W-1:0] araddr;
		logic rready;
	} axil_req_t;

	typedef struct packed {
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [AXI_DATA_W-1:0] rdata;
		logic [1:0] rresp;
	} axil_rsp_t;

	typedef struct packed {
		logic role_master;
		logic layer_reset;
		logic tx_disable;
		logic amp_high;
		logic low_power;
		logic eee_enable;
		logic loopback;
	} media_ctrl_t;

endpackage : media_regs_pkg

// ### hdl/layer_reset_seq.sv
// Sequencer that holds the attachment layer in reset for a fixed number of cycles
`timescale 1ns/10ps
module layer_reset_seq
	import media_regs_pkg::*;
#(
	parameter int HOLD_CYCLES = LAYER_RESET_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic start,
	output logic busy
);

	typedef struct packed {
		seq_state_t state;
		logic [RESET_CNT_W-1:0] count;
		logic busy;
	} seq_regs_t;

	localparam logic [RESET_CNT_W-1:0] LAST_COUNT = RESET_CNT_W'(HOLD_CYCLES - 1);

	seq_regs_t st_r;
	seq_regs_t st_nxt;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	// A start during the hold restarts the count, so a late request is never lost
	always_comb begin
		st_nxt = st_r;
		case (st_r.state)
			SEQ_IDLE: begin
				if (start) begin
					st_nxt.state = SEQ_HOLD;
					st_nxt.count = '0;
					st_nxt.busy = 1'b1;
				end
			end
			SEQ_HOLD: begin
				if (start) begin
					st_nxt.count = '0;
				end else if (st_r.count == LAST_COUNT) begin
					st_nxt.state = SEQ_IDLE;
					st_nxt.busy = 1'b0;
				end else begin
					st_nxt.count = st_r.count + 1'b1;
				end
			end
			default: begin
				st_nxt.state = SEQ_IDLE;
				st_nxt.busy = 1'b0;
			end
		endcase
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= '{state: SEQ_IDLE, count: '0, busy: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign busy = st_r.busy;

endmodule : layer_reset_seq

// ### hdl/phy_media_attach_ctrl_regs.sv
// Media attachment control and ability registers behind an AXI4-Lite slave
//
// Notes on behaviour
// - Second extended-ability word always reads one in bit 11.
// - Extended-ability word reads one in bit 2, all other bits zero.
// - Role bit 14 is read/write, resets to one; one means link master.
// - Link-type field bits 3 to 0 always read 0010b for 10BASE-T1L.
// - Writing one to layer bit 15 resets the layer; bit clears itself.
// - Layer bit 14 read/write, resets zero; one disables the transmitter.
// - Layer bit 12 read/write, resets zero; one selects 2.4 Vpp, zero 1.0 Vpp.
// - Layer bit 11 read/write, resets zero; one requests low-power mode.
// - Layer bit 10 read/write, resets zero; one enables energy-efficient operation.
// - Layer bit 0 read/write, resets zero; one turns on layer loopback.
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
module phy_media_attach_ctrl_regs
	import media_regs_pkg::*;
#(
	parameter int HOLD_CYCLES = LAYER_RESET_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire axil_req_t axil_req,
	output axil_rsp_t axil_rsp,
	output media_ctrl_t media_ctrl
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic aw_held;
		logic [AXI_ADDR_W-1:0] aw_addr;
		logic w_held;
		logic [AXI_DATA_W-1:0] w_data;
		logic [STRB_W-1:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [AXI_DATA_W-1:0] rdata;
		logic [1:0] rresp;
		logic role_master;
		logic tx_disable;
		logic amp_high;
		logic low_power;
		logic eee_enable;
		logic loopback;
		logic reset_start;
	} regs_state_t;

	localparam regs_state_t STATE_RESET = '{
		aw_held: 1'b0,
		aw_addr: '0,
		w_held: 1'b0,
		w_data: '0,
		w_strb: '0,
		bvalid: 1'b0,
		bresp: RESP_OKAY,
		rvalid: 1'b0,
		rdata: '0,
		rresp: RESP_OKAY,
		role_master: RST_MEDIUM_ROLE_CONTROL[BIT_ROLE_MASTER],
		tx_disable: RST_ATTACH_LAYER_CONTROL[BIT_TX_DISABLE],
		amp_high: RST_ATTACH_LAYER_CONTROL[BIT_AMP_HIGH],
		low_power: RST_ATTACH_LAYER_CONTROL[BIT_LOW_POWER],
		eee_enable: RST_ATTACH_LAYER_CONTROL[BIT_EEE_ENABLE],
		loopback: RST_ATTACH_LAYER_CONTROL[BIT_LOOPBACK],
		reset_start: 1'b0
	};

	regs_state_t st_r;
	regs_state_t st_nxt;
	logic layer_busy;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Registers are 16 bits wide, so only the two low byte lanes can change anything
	function automatic logic [REG_W-1:0] merge_lanes(
		input logic [REG_W-1:0] old_val,
		input logic [AXI_DATA_W-1:0] data,
		input logic [STRB_W-1:0] strb
	);
		logic [REG_W-1:0] res;
		res = old_val;
		if (strb[0]) begin
			res[7:0] = data[7:0];
		end
		if (strb[1]) begin
			res[15:8] = data[15:8];
		end
		return res;
	endfunction : merge_lanes

	// Byte offset bits are ignored; a word lives at any address within it
	function automatic logic [AXI_ADDR_W-1:0] word_addr(input logic [AXI_ADDR_W-1:0] a);
		return {a[AXI_ADDR_W-1:2], 2'h0};
	endfunction : word_addr

	// ----------------------------------------------------------------
	// Read view of the four words
	// ----------------------------------------------------------------
	logic [REG_W-1:0] ext_two_view;
	logic [REG_W-1:0] ext_view;
	logic [REG_W-1:0] role_view;
	logic [REG_W-1:0] layer_view;

	// Fixed words are built from constants, so no write path can reach them
	always_comb begin
		ext_two_view = '0;
		ext_two_view[BIT_SINGLE_PAIR_EXT] = RST_EXT_ABILITY_TWO[BIT_SINGLE_PAIR_EXT];
		ext_view = '0;
		ext_view[BIT_LONG_REACH_10M] = RST_EXT_ABILITY[BIT_LONG_REACH_10M];
		role_view = '0;
		role_view[BIT_ROLE_MASTER] = st_r.role_master;
		role_view[TYPE_MSB:TYPE_LSB] = TYPE_10BASE_T1L;
		layer_view = '0;
		layer_view[BIT_LAYER_RESET] = layer_busy;
		layer_view[BIT_TX_DISABLE] = st_r.tx_disable;
		layer_view[BIT_AMP_HIGH] = st_r.amp_high;
		layer_view[BIT_LOW_POWER] = st_r.low_power;
		layer_view[BIT_EEE_ENABLE] = st_r.eee_enable;
		layer_view[BIT_LOOPBACK] = st_r.loopback;
	end

	// ----------------------------------------------------------------
	// Channel handshakes
	// ----------------------------------------------------------------
	logic aw_take;
	logic w_take;
	logic ar_take;
	logic aw_have;
	logic w_have;
	logic [AXI_ADDR_W-1:0] wr_addr;
	logic [AXI_DATA_W-1:0] wr_data;
	logic [STRB_W-1:0] wr_strb;

	// Address and data are refused while their own half is parked or a response is still owed
	assign axil_rsp.awready = !st_r.aw_held && !st_r.bvalid;
	assign axil_rsp.wready = !st_r.w_held && !st_r.bvalid;
	assign axil_rsp.arready = !st_r.rvalid;
	assign aw_take = axil_req.awvalid && axil_rsp.awready;
	assign w_take = axil_req.wvalid && axil_rsp.wready;
	assign ar_take = axil_req.arvalid && axil_rsp.arready;

	// Use a held beat or one arriving now, so the write commits on the last taking edge
	assign aw_have = st_r.aw_held || aw_take;
	assign w_have = st_r.w_held || w_take;
	assign wr_addr = st_r.aw_held ? st_r.aw_addr : axil_req.awaddr;
	assign wr_data = st_r.w_held ? st_r.w_data : axil_req.wdata;
	assign wr_strb = st_r.w_held ? st_r.w_strb : axil_req.wstrb;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// Both paths share one map, so a word cannot be mapped for reads and lost for writes
	typedef enum logic [2:0] {SEL_NONE, SEL_EXT_TWO, SEL_EXT, SEL_ROLE, SEL_LAYER} reg_sel_t;

	reg_sel_t wr_sel;
	reg_sel_t rd_sel;

	// Write decode follows the parked or arriving address of the write about to commit
	always_comb begin
		logic [AXI_ADDR_W-1:0] wa;
		wa = word_addr(wr_addr);
		if (wa == ADDR_EXT_ABILITY_TWO) begin
			wr_sel = SEL_EXT_TWO;
		end else if (wa == ADDR_EXT_ABILITY) begin
			wr_sel = SEL_EXT;
		end else if (wa == ADDR_MEDIUM_ROLE_CONTROL) begin
			wr_sel = SEL_ROLE;
		end else if (wa == ADDR_ATTACH_LAYER_CONTROL) begin
			wr_sel = SEL_LAYER;
		end else begin
			wr_sel = SEL_NONE;
		end
	end

	// Read decode follows the bus address; it only matters at the taking edge
	always_comb begin
		logic [AXI_ADDR_W-1:0] ra;
		ra = word_addr(axil_req.araddr);
		if (ra == ADDR_EXT_ABILITY_TWO) begin
			rd_sel = SEL_EXT_TWO;
		end else if (ra == ADDR_EXT_ABILITY) begin
			rd_sel = SEL_EXT;
		end else if (ra == ADDR_MEDIUM_ROLE_CONTROL) begin
			rd_sel = SEL_ROLE;
		end else if (ra == ADDR_ATTACH_LAYER_CONTROL) begin
			rd_sel = SEL_LAYER;
		end else begin
			rd_sel = SEL_NONE;
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [REG_W-1:0] merged;
		merged = '0;
		st_nxt = st_r;
		st_nxt.reset_start = 1'b0;

		// Write response retires here; new halves are refused until the cycle after
		if (st_r.bvalid && axil_req.bready) begin
			st_nxt.bvalid = 1'b0;
		end

		// Park whichever half of a write arrives alone
		if (aw_take) begin
			st_nxt.aw_held = 1'b1;
			st_nxt.aw_addr = axil_req.awaddr;
		end
		if (w_take) begin
			st_nxt.w_held = 1'b1;
			st_nxt.w_data = axil_req.wdata;
			st_nxt.w_strb = axil_req.wstrb;
		end

		// Commit once both halves are present
		if (aw_have && w_have && !st_r.bvalid) begin
			st_nxt.aw_held = 1'b0;
			st_nxt.w_held = 1'b0;
			st_nxt.bvalid = 1'b1;
			st_nxt.bresp = RESP_OKAY;
			if (wr_sel == SEL_ROLE) begin
				merged = merge_lanes(role_view, wr_data, wr_strb);
				st_nxt.role_master = merged[BIT_ROLE_MASTER];
			end else if (wr_sel == SEL_LAYER) begin
				merged = merge_lanes(layer_view, wr_data, wr_strb);
				// Writing zero to a busy reset bit cannot abort the reset
				st_nxt.reset_start = merged[BIT_LAYER_RESET] && wr_strb[1];
				st_nxt.tx_disable = merged[BIT_TX_DISABLE];
				st_nxt.amp_high = merged[BIT_AMP_HIGH];
				st_nxt.low_power = merged[BIT_LOW_POWER];
				st_nxt.eee_enable = merged[BIT_EEE_ENABLE];
				st_nxt.loopback = merged[BIT_LOOPBACK];
			end else if (wr_sel == SEL_EXT_TWO || wr_sel == SEL_EXT) begin
				st_nxt.bresp = RESP_OKAY;
			end else begin
				st_nxt.bresp = RESP_SLVERR;
			end
		end

		// Read channel: one read under way, data captured at the taking edge
		if (st_r.rvalid && axil_req.rready) begin
			st_nxt.rvalid = 1'b0;
		end
		if (ar_take) begin
			st_nxt.rvalid = 1'b1;
			st_nxt.rresp = RESP_OKAY;
			st_nxt.rdata = '0;
			if (rd_sel == SEL_EXT_TWO) begin
				st_nxt.rdata[REG_W-1:0] = ext_two_view;
			end else if (rd_sel == SEL_EXT) begin
				st_nxt.rdata[REG_W-1:0] = ext_view;
			end else if (rd_sel == SEL_ROLE) begin
				st_nxt.rdata[REG_W-1:0] = role_view;
			end else if (rd_sel == SEL_LAYER) begin
				st_nxt.rdata[REG_W-1:0] = layer_view;
			end else begin
				st_nxt.rresp = RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// State register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= STATE_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	// ----------------------------------------------------------------
	// Layer reset sequencer
	// ----------------------------------------------------------------
	// A restart while busy extends the hold, except a write committed at the edge that ends it: busy then drops for one cycle
	layer_reset_seq #(
		.HOLD_CYCLES(HOLD_CYCLES)
	) u_layer_reset_seq (
		.clk(clk),
		.rst_n(rst_n),
		.start(st_r.reset_start),
		.busy(layer_busy)
	);

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign axil_rsp.bvalid = st_r.bvalid;
	assign axil_rsp.bresp = st_r.bresp;
	assign axil_rsp.rvalid = st_r.rvalid;
	assign axil_rsp.rdata = st_r.rdata;
	assign axil_rsp.rresp = st_r.rresp;

	// Controls drive the layer straight from flip-flops
	assign media_ctrl.role_master = st_r.role_master;
	assign media_ctrl.layer_reset = layer_busy;
	assign media_ctrl.tx_disable = st_r.tx_disable;
	assign media_ctrl.amp_high = st_r.amp_high;
	assign media_ctrl.low_power = st_r.low_power;
	assign media_ctrl.eee_enable = st_r.eee_enable;
	assign media_ctrl.loopback = st_r.loopback;

endmodule : phy_media_attach_ctrl_regs

// ### sim/media_regs_asserts.sv
// Concurrent checks on the media control register block
`timescale 1ns/10ps
module media_regs_asserts
	import media_regs_pkg::*;
#(
	parameter int HOLD_CYCLES = LAYER_RESET_CYCLES
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire axil_req_t axil_req,
	input wire axil_rsp_t axil_rsp,
	input wire media_ctrl_t media_ctrl
);
	// --------------------
	// Short aliases and handshakes
	// --------------------
	axil_req_t q;
	axil_rsp_t p;
	media_ctrl_t m;
	logic wr_go;
	logic rd_go;
	assign q = axil_req;
	assign p = axil_rsp;
	assign m = media_ctrl;
	// Both write halves taken together, the way the bench offers them
	assign wr_go = q.awvalid && p.awready && q.wvalid && p.wready;
	assign rd_go = q.arvalid && p.arready;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	// --------------------
	// Bus answers
	// --------------------
	rd_answer_a: assert property (rd_go |=> p.rvalid) else $error("read answer late");
	wr_answer_a: assert property (wr_go |=> p.bvalid) else $error("write answer late");
	b_hold_a: assert property (p.bvalid && !q.bready |=> p.bvalid && $stable(p.bresp))
		else $error("write answer dropped");
	r_hold_a: assert property (p.rvalid && !q.rready |=> p.rvalid && $stable(p.rdata))
		else $error("read answer dropped");
	// Reached on every transfer, unlike the hold checks above
	wr_refuse_a: assert property (p.bvalid |-> !p.awready && !p.wready)
		else $error("write taken while answer owed");
	rd_refuse_a: assert property (p.rvalid |-> !p.arready)
		else $error("read taken while answer owed");

	// --------------------
	// Register contents
	// --------------------
	ability_two_a: assert property (
		rd_go && q.araddr == ADDR_EXT_ABILITY_TWO |=> p.rdata == 32'h00000800)
		else $error("ability two word wrong");
	ability_a: assert property (
		rd_go && q.araddr == ADDR_EXT_ABILITY |=> p.rdata == 32'h00000004)
		else $error("ability word wrong");
	link_type_a: assert property (
		rd_go && q.araddr == ADDR_MEDIUM_ROLE_CONTROL |=> (p.rdata & 32'hffffbfff) == 32'h2)
		else $error("link type field wrong");
	reset_value_a: assert property ($rose(rst_n) |-> m == 7'h40)
		else $error("control reset value wrong");
	role_write_a: assert property (
		wr_go && q.awaddr == ADDR_MEDIUM_ROLE_CONTROL && q.wstrb[1]
		|=> m.role_master == $past(q.wdata[14])) else $error("role bit not written");
	ctrl_write_a: assert property (
		wr_go && q.awaddr == ADDR_ATTACH_LAYER_CONTROL && q.wstrb[1:0] == 2'h3
		|=> m[4:0] == $past({q.wdata[14], q.wdata[12:10], q.wdata[0]}))
		else $error("layer control bits not written");
	layer_start_a: assert property (
		wr_go && q.awaddr == ADDR_ATTACH_LAYER_CONTROL && q.wstrb[1] && q.wdata[15]
		|=> ##1 m.layer_reset) else $error("layer reset not started");
	layer_clear_a: assert property (m.layer_reset |-> ##[1:1000] !m.layer_reset)
		else $error("layer reset never clears");

	// Main scenarios reached
	cover property (wr_go && q.wstrb[1] && q.wdata[15]);
	cover property ($fell(m.layer_reset));
	cover property (p.rvalid && p.rresp == RESP_SLVERR);
endmodule : media_regs_asserts

bind phy_media_attach_ctrl_regs media_regs_asserts #(.HOLD_CYCLES(HOLD_CYCLES)) chk_i (
	.clk(clk), .rst_n(rst_n), .axil_req(axil_req), .axil_rsp(axil_rsp),
	.media_ctrl(media_ctrl));

// ### sim/testbench.sv
// Self-checking bench for the media control registers over AXI4-Lite
`timescale 1ns/10ps
module testbench
	import media_regs_pkg::*;
;
	localparam int HOLD = 8;
	logic clk;
	logic rst_n;
	axil_req_t req;
	axil_rsp_t rsp;
	media_ctrl_t ctrl;
	int errors;
	int n_compared;
	logic [33:0] exp_r[$];
	logic [1:0] exp_b[$];
	logic [15:0] lm;
	logic [31:0] w;
	logic [3:0] s;
	logic [15:0] ad[4];
	logic [15:0] rv[4];

	phy_media_attach_ctrl_regs #(.HOLD_CYCLES(HOLD)) dut (.clk(clk), .rst_n(rst_n),
		.axil_req(req), .axil_rsp(rsp), .media_ctrl(ctrl));

	// Free-running 40 MHz clock
	initial clk = 1'h0;
	always #12.5 clk = ~clk;

	// --------------------
	// Shared tasks
	// --------------------
	task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Write: address and data offered together, each dropped once taken
	task automatic wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] st,
		input logic [1:0] r);
		exp_b.push_back(r);
		@(posedge clk);
		req.awvalid <= 1'h1;
		req.awaddr <= a;
		req.wvalid <= 1'h1;
		req.wdata <= d;
		req.wstrb <= st;
		req.bready <= 1'h1;
		do begin
			@(posedge clk);
			if (rsp.awready) req.awvalid <= 1'h0;
			if (rsp.wready) req.wvalid <= 1'h0;
		end while (!rsp.bvalid);
		req.bready <= 1'h0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [15:0] e, input logic [1:0] r);
		exp_r.push_back({r, 16'h0, e});
		@(posedge clk);
		req.arvalid <= 1'h1;
		req.araddr <= a;
		req.rready <= 1'h1;
		do begin
			@(posedge clk);
			if (rsp.arready) req.arvalid <= 1'h0;
		end while (!rsp.rvalid);
		req.rready <= 1'h0;
	endtask : rd

	task automatic give_verdict();
		$display("compared %0d errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : give_verdict

	// Answer watcher: each completed response is matched against the oldest note
	always @(posedge clk) begin
		if (rst_n && rsp.bvalid && req.bready)
			chk("bresp", {32'h0, exp_b.pop_front()}, {32'h0, rsp.bresp});
		if (rst_n && rsp.rvalid && req.rready)
			chk("rdata", exp_r.pop_front(), {rsp.rresp, rsp.rdata});
	end

	// Watchdog, far beyond the fewer than two hundred cycles the sequence needs
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		give_verdict();
	end

	// --------------------
	// Main sequence
	// --------------------
	initial begin
		req = '0;
		rst_n = 1'h0;
		errors = 0;
		n_compared = 0;
		lm = 16'h0;
		ad = '{ADDR_EXT_ABILITY_TWO, ADDR_EXT_ABILITY, ADDR_MEDIUM_ROLE_CONTROL,
			ADDR_ATTACH_LAYER_CONTROL};
		rv = '{16'h0800, 16'h0004, 16'h4002, 16'h0000};
		w = $urandom(20);
		repeat (5) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		chk("ctrl", 34'(ctrl), 34'h40);
		foreach (ad[i]) rd(ad[i], rv[i], RESP_OKAY);
		// Read-only words shrug off writes but still answer OKAY
		for (int i = 0; i < 2; i++) begin
			wr(ad[i], 32'hffffffff, 4'hf, RESP_OKAY);
			rd(ad[i], rv[i], RESP_OKAY);
		end
		wr(ADDR_MEDIUM_ROLE_CONTROL, 32'hffffbfff, 4'hf, RESP_OKAY);
		rd(ADDR_MEDIUM_ROLE_CONTROL, 16'h0002, RESP_OKAY);
		chk("role", 34'(ctrl.role_master), 34'h0);
		wr(ADDR_MEDIUM_ROLE_CONTROL, 32'hffffffff, 4'hf, RESP_OKAY);
		rd(ADDR_MEDIUM_ROLE_CONTROL, 16'h4002, RESP_OKAY);
		// Random data and strobes; only the two low lanes may change anything
		for (int i = 0; i < 12; i++) begin
			w = $urandom();
			s = 4'($urandom());
			w[15] = 1'h0;
			if (s[0]) lm[7:0] = w[7:0];
			if (s[1]) lm[15:8] = w[15:8];
			lm = lm & 16'h5c01;
			wr(ADDR_ATTACH_LAYER_CONTROL, w, s, RESP_OKAY);
			rd(ADDR_ATTACH_LAYER_CONTROL, lm, RESP_OKAY);
			chk("ctrl", 34'(ctrl[4:0]), 34'({lm[14], lm[12:10], lm[0]}));
		end
		// Layer reset reads back busy, then clears by itself, control bits kept
		wr(ADDR_ATTACH_LAYER_CONTROL, {16'h0, lm | 16'h8000}, 4'h3, RESP_OKAY);
		rd(ADDR_ATTACH_LAYER_CONTROL, lm | 16'h8000, RESP_OKAY);
		chk("layer_reset", 34'(ctrl.layer_reset), 34'h1);
		repeat (HOLD + 4) @(posedge clk);
		rd(ADDR_ATTACH_LAYER_CONTROL, lm, RESP_OKAY);
		chk("layer_reset", 34'(ctrl.layer_reset), 34'h0);
		// Unmapped place
		wr(16'h0100, 32'hffffffff, 4'hf, RESP_SLVERR);
		rd(16'h0100, 16'h0, RESP_SLVERR);
		// Second reset in mid-run restores the documented values
		@(posedge clk);
		rst_n <= 1'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		chk("ctrl", 34'(ctrl), 34'h40);
		rd(ADDR_ATTACH_LAYER_CONTROL, 16'h0, RESP_OKAY);
		rd(ADDR_MEDIUM_ROLE_CONTROL, 16'h4002, RESP_OKAY);
		repeat (2) @(posedge clk);
		give_verdict();
	end
endmodule : testbench
